// ---- fcl_pkg.sv ----
// fcl_pkg: register map, field layout and types of the closed loop feedback block
package fcl_pkg;
   // register byte offsets on the wishbone slave
   localparam logic [7:0] FCL_CTRL      = 8'h00;
   localparam logic [7:0] FCL_NUM_A     = 8'h04;
   localparam logic [7:0] FCL_NUM_B     = 8'h08;
   localparam logic [7:0] FCL_DEN_A     = 8'h0C;
   localparam logic [7:0] FCL_DEN_B     = 8'h10;
   localparam logic [7:0] FCL_FILT      = 8'h14;
   localparam logic [7:0] FCL_MOT_CUM   = 8'h18;
   localparam logic [7:0] FCL_GEAR_CUM  = 8'h1C;
   localparam logic [7:0] FCL_LOAD_CUM  = 8'h20;
   localparam logic [7:0] FCL_LOAD_INFO = 8'h24;
   localparam logic [7:0] FCL_STATUS    = 8'h28;
   localparam logic [7:0] FCL_HOME_POS  = 8'h2C;
   localparam logic [7:0] FCL_FB_POS    = 8'h30;
   // word address mask, low two bits are byte lanes
   localparam logic [7:0] FCL_WORD_MSK  = 8'hFC;
   // control register bit positions
   localparam int FCL_CTRL_MODE = 0;
   localparam int FCL_CTRL_SWEN = 1;
   localparam int FCL_CTRL_POL  = 2;
   // status register bit positions
   localparam int FCL_ST_FULL  = 0;
   localparam int FCL_ST_MATCH = 1;
   localparam int FCL_ST_HOMED = 2;
   localparam int FCL_ST_FAIL  = 3;
   localparam int FCL_ST_BUSY  = 4;
   // reset values
   localparam logic [15:0] FCL_GEAR_RST = 16'h0001;
   localparam logic [12:0] FCL_FILT_RST = 13'h000A;
   // filter limits: zero is semi closed, full value is load side only
   localparam logic [12:0] FCL_FILT_SEMI = 13'h0000;
   localparam logic [12:0] FCL_FILT_FULL = 13'h1194;
   // operation mode value that selects the fully closed system
   localparam logic FCL_MODE_FULL = 1'b1;
   // one sampled control cycle from both encoders
   typedef struct packed {
      logic signed [15:0] motor_delta; // motor pulses this cycle
      logic signed [15:0] load_delta;  // raw load pulses this cycle
      logic               load_mark;   // reference mark or z passed
   } fcl_enc_t;
   // homing sequence states
   typedef enum logic [1:0] {
      FCL_H_IDLE = 2'b00,
      FCL_H_SEEK = 2'b01,
      FCL_H_DONE = 2'b10,
      FCL_H_FAIL = 2'b11
   } fcl_home_t;
endpackage

// ---- fcl_gear.sv ----
// fcl_gear: feedback electronic gear with remainder carry
`timescale 1ns/1ps
module fcl_gear
   import fcl_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               step_i,  // one control cycle
   input  wire logic signed [15:0] delta_i, // before-gear pulses
   input  wire logic        [31:0] num_i,   // numerator product
   input  wire logic        [31:0] den_i,   // denominator product
   output logic signed      [31:0] cum_o    // after-gear count
);
   // all state of the scaler
   typedef struct packed {
      logic signed [31:0] rem; // carried division remainder
      logic signed [31:0] cum; // after-gear cumulative count
   } fcl_gear_st_t;

   fcl_gear_st_t       st_ff;  // registered state
   fcl_gear_st_t       nxt_st; // next state
   logic signed [48:0] acc;    // remainder plus scaled sample
   logic signed [48:0] den;    // divisor, never negative
   logic signed [48:0] quo;    // whole after-gear pulses

   // scale one sample and keep what the division leaves over
   always_comb begin
      nxt_st = st_ff;
      den    = 49'($signed({1'b0, den_i}));
      acc    = 49'(st_ff.rem) + 49'(delta_i) * 49'($signed({1'b0, num_i}));
      quo    = '0;
      // zero divisor is a bad setting: hold rather than divide
      if (step_i && den_i != '0) begin
         quo        = acc / den;
         nxt_st.rem = 32'(acc - quo * den);
         nxt_st.cum = st_ff.cum + 32'(quo);
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cum_o = st_ff.cum;
endmodule

// ---- fcl_top.sv ----
// fcl_top: fully closed loop feedback counting, blending and homing
// Contract
// - load count advances on movement without alarm
// - load information clears at mark or z
// - after-gear count equals before-gear times gear
// - gear and load counts rise together equal
// - polarity select reverses load count direction
// - filter zero semi, middle dual, 4500 full
// - filter setting resets to ten
// - larger filter weighs load feedback more
// - homing uses load feedback, motor z ignored
// - mark must pass before dog turns off
// - mode one fully closed, zero semi closed
// - with switching, controller command picks loop
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module fcl_top
   import fcl_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic             wb_ack_o,
   output logic      [31:0] wb_dat_o,
   input  wire logic        sample_i,
   input  wire fcl_enc_t    enc_i,
   input  wire logic        alarm_i,
   input  wire logic        loop_switch_cmd_i,
   input  wire logic        home_start_i,
   input  wire logic        dog_i,
   output logic      [31:0] fb_pos_o,
   output logic             full_loop_o,
   output logic             homed_o
);
   // all state of the block except the gear scaler state held in u_gear
   typedef struct packed {
      logic               ack;       // bus answer
      logic [31:0]        rdat;      // bus read data
      logic               mode;      // operation_mode_select
      logic               swen;      // loop_switch_enable
      logic               pol;       // load_encoder_polarity_select
      logic [15:0]        na;        // gear_numerator_a
      logic [15:0]        nb;        // gear_numerator_b
      logic [15:0]        da;        // gear_denominator_a
      logic [15:0]        db;        // gear_denominator_b
      logic [12:0]        filt;      // dual_feedback_filter_setting
      logic signed [31:0] mot_cum;   // before-gear motor count
      logic signed [31:0] load_cum;  // load cumulative count
      logic signed [31:0] load_info; // load information, mark relative
      logic signed [31:0] diff_f;    // filtered load minus motor
      logic signed [31:0] fb;        // feedback handed to the loop
      logic signed [31:0] home_pos;  // latched home position
      fcl_home_t          home;      // homing state
      logic               mark_seen; // mark crossed while seeking
      logic               dog_d;     // dog level one cycle ago
      logic               full;      // fully closed loop in use
   } fcl_st_t;

   fcl_st_t            st_ff;     // registered state
   fcl_st_t            nxt_st;    // next state
   logic signed [31:0] gear_cum;  // after-gear count from scaler
   logic        [31:0] num_prod;  // numerator product
   logic        [31:0] den_prod;  // denominator product
   logic signed [15:0] load_step; // load pulses after polarity
   logic               bus_req;   // new bus request this cycle
   logic [7:0]         word_adr;  // word aligned address
   logic signed [31:0] diff;      // load minus after-gear motor
   logic signed [47:0] blend;     // weighted filter correction
   logic               full_sel;  // loop selection this cycle
   logic               counts_eq; // gear and load counts agree

   // merge write data into a register by byte lanes
   function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign num_prod = st_ff.na * st_ff.nb;
   assign den_prod = st_ff.da * st_ff.db;

   fcl_gear u_gear (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .step_i  (sample_i),
      .delta_i (enc_i.motor_delta),
      .num_i   (num_prod),
      .den_i   (den_prod),
      .cum_o   (gear_cum)
   );

   assign load_step = st_ff.pol ? -enc_i.load_delta : enc_i.load_delta;

   assign bus_req  = wb_cyc_i && wb_stb_i && !st_ff.ack;
   assign word_adr = wb_adr_i & FCL_WORD_MSK;
   assign diff     = st_ff.load_cum - gear_cum;

   assign counts_eq = (gear_cum == st_ff.load_cum);

   // with switching on, controller command decides
   assign full_sel = (st_ff.mode == FCL_MODE_FULL) && (!st_ff.swen || loop_switch_cmd_i);

   assign blend = (48'(diff) - 48'(st_ff.diff_f)) * 48'($signed({1'b0, st_ff.filt}));

   // next state: bus, counters, blend and homing
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.ack  = bus_req;
      nxt_st.full = full_sel;
      nxt_st.dog_d = dog_i;

      // bus slave: answer one cycle after the request
      if (bus_req) begin
         // unmapped reads return zero
         nxt_st.rdat = '0;
         unique case (word_adr)
            FCL_CTRL: begin
               nxt_st.rdat[FCL_CTRL_MODE] = st_ff.mode;
               nxt_st.rdat[FCL_CTRL_SWEN] = st_ff.swen;
               nxt_st.rdat[FCL_CTRL_POL]  = st_ff.pol;
            end
            FCL_NUM_A:     nxt_st.rdat = 32'(st_ff.na);
            FCL_NUM_B:     nxt_st.rdat = 32'(st_ff.nb);
            FCL_DEN_A:     nxt_st.rdat = 32'(st_ff.da);
            FCL_DEN_B:     nxt_st.rdat = 32'(st_ff.db);
            FCL_FILT:      nxt_st.rdat = 32'(st_ff.filt);
            FCL_MOT_CUM:   nxt_st.rdat = st_ff.mot_cum;
            FCL_GEAR_CUM:  nxt_st.rdat = gear_cum;
            FCL_LOAD_CUM:  nxt_st.rdat = st_ff.load_cum;
            FCL_LOAD_INFO: nxt_st.rdat = st_ff.load_info;
            FCL_STATUS: begin
               nxt_st.rdat[FCL_ST_FULL]  = st_ff.full;
               nxt_st.rdat[FCL_ST_MATCH] = counts_eq;
               nxt_st.rdat[FCL_ST_HOMED] = (st_ff.home == FCL_H_DONE);
               nxt_st.rdat[FCL_ST_FAIL]  = (st_ff.home == FCL_H_FAIL);
               nxt_st.rdat[FCL_ST_BUSY]  = (st_ff.home == FCL_H_SEEK);
            end
            FCL_HOME_POS:  nxt_st.rdat = st_ff.home_pos;
            FCL_FB_POS:    nxt_st.rdat = st_ff.fb;
            default:       nxt_st.rdat = '0;
         endcase
         // writes land at the edge that raises ack
         if (wb_we_i) begin
            unique case (word_adr)
               FCL_CTRL: begin
                  if (wb_sel_i[0]) begin
                     nxt_st.mode = wb_dat_i[FCL_CTRL_MODE];
                     nxt_st.swen = wb_dat_i[FCL_CTRL_SWEN];
                     nxt_st.pol  = wb_dat_i[FCL_CTRL_POL];
                  end
               end
               FCL_NUM_A: nxt_st.na = 16'(wr_merge(32'(st_ff.na), wb_dat_i, wb_sel_i));
               FCL_NUM_B: nxt_st.nb = 16'(wr_merge(32'(st_ff.nb), wb_dat_i, wb_sel_i));
               FCL_DEN_A: nxt_st.da = 16'(wr_merge(32'(st_ff.da), wb_dat_i, wb_sel_i));
               FCL_DEN_B: nxt_st.db = 16'(wr_merge(32'(st_ff.db), wb_dat_i, wb_sel_i));
               FCL_FILT: begin
                  nxt_st.filt = 13'(wr_merge(32'(st_ff.filt), wb_dat_i, wb_sel_i));
                  // settings above full act as load side only
                  if (nxt_st.filt > FCL_FILT_FULL) begin
                     nxt_st.filt = FCL_FILT_FULL;
                  end
               end
               // counters and status are read only
               default: begin
               end
            endcase
         end
      end

      // all counts step on one sample
      if (sample_i) begin
         nxt_st.mot_cum = st_ff.mot_cum + 32'(enc_i.motor_delta);
         if (!alarm_i) begin
            nxt_st.load_cum  = st_ff.load_cum + 32'(load_step);
            nxt_st.load_info = st_ff.load_info + 32'(load_step);
         end
         if (enc_i.load_mark && enc_i.load_delta != '0) begin
            nxt_st.load_info = '0;
         end

         if (st_ff.filt == FCL_FILT_SEMI) begin
            nxt_st.diff_f = '0;
         end else if (st_ff.filt >= FCL_FILT_FULL) begin
            nxt_st.diff_f = diff;
         end else begin
            nxt_st.diff_f = st_ff.diff_f + 32'(blend / 48'($signed({1'b0, FCL_FILT_FULL})));
         end

         if (st_ff.mode != FCL_MODE_FULL) begin
            nxt_st.fb = st_ff.mot_cum;
         end else if (!st_ff.full) begin
            nxt_st.fb = gear_cum;
         end else begin
            nxt_st.fb = gear_cum + st_ff.diff_f;
         end
      end

      unique case (st_ff.home)
         FCL_H_IDLE, FCL_H_DONE, FCL_H_FAIL: begin
            if (home_start_i) begin
               nxt_st.home      = FCL_H_SEEK;
               nxt_st.mark_seen = 1'b0;
            end
         end
         FCL_H_SEEK: begin
            if (sample_i && enc_i.load_mark && !st_ff.mark_seen) begin
               nxt_st.mark_seen = 1'b1;
               nxt_st.home_pos  = nxt_st.load_cum;
            end
            if (st_ff.dog_d && !dog_i) begin
               nxt_st.home = nxt_st.mark_seen ? FCL_H_DONE : FCL_H_FAIL;
            end
         end
      endcase
   end

   // state register, every field has a reset value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff      <= '0;
         st_ff.na   <= FCL_GEAR_RST;
         st_ff.nb   <= FCL_GEAR_RST;
         st_ff.da   <= FCL_GEAR_RST;
         st_ff.db   <= FCL_GEAR_RST;
         st_ff.filt <= FCL_FILT_RST;
         st_ff.home <= FCL_H_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state register
   assign wb_ack_o    = st_ff.ack;
   assign wb_dat_o    = st_ff.rdat;
   assign fb_pos_o    = st_ff.fb;
   assign full_loop_o = st_ff.full;
   assign homed_o     = (st_ff.home == FCL_H_DONE);
endmodule

// ---- fcl_top_checker.sv ----
// fcl_top_checker: bus, feedback and homing timing checks on fcl_top pins
`timescale 1ns/1ps
module fcl_top_checker
   import fcl_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        sample_i,
   input wire fcl_enc_t    enc_i,
   input wire logic        alarm_i,
   input wire logic        loop_switch_cmd_i,
   input wire logic        home_start_i,
   input wire logic        dog_i,
   input wire logic [31:0] fb_pos_o,
   input wire logic        full_loop_o,
   input wire logic        homed_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // request taken at this edge
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   a_ack_next: assert property (take |=> wb_ack_o) else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_cause: assert property (!take |=> !wb_ack_o) else $error("ack without request");
   a_dat_hold: assert property (!take |=> $stable(wb_dat_o)) else $error("read data moved");
   // unmapped space reads as zero
   a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i >= 8'h34 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_fb_hold: assert property (!sample_i |=> $stable(fb_pos_o)) else $error("fb moved off sample");
   a_home_rise: assert property ($rose(homed_o) |-> $past(dog_i, 2) && !$past(dog_i))
      else $error("homed without dog fall");
   a_homed_keep: assert property (homed_o && !home_start_i |=> homed_o) else $error("homed lost");
   a_homed_clear: assert property ($fell(homed_o) |-> $past(home_start_i)) else $error("homed fell early");
   // main scenarios reached
   c_write: cover property (take && wb_we_i);
   c_homed: cover property ($rose(homed_o));
   c_full: cover property ($rose(full_loop_o));
endmodule
bind fcl_top fcl_top_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o), .sample_i(sample_i), .enc_i(enc_i), .alarm_i(alarm_i), .dog_i(dog_i),
   .loop_switch_cmd_i(loop_switch_cmd_i), .home_start_i(home_start_i), .fb_pos_o(fb_pos_o),
   .full_loop_o(full_loop_o), .homed_o(homed_o));

// ---- fcl_enc_model.sv ----
// fcl_enc_model: motor and load encoder source pacing the control cycle
`timescale 1ns/1ps
module fcl_enc_model
   import fcl_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               run_i,   // axis moving
   input  wire logic signed [15:0] mot_i,   // motor pulses per cycle
   input  wire logic signed [15:0] load_i,  // load pulses per cycle
   input  wire logic               mark_i,  // mark passed in this stretch
   output logic                    sample_o,
   output fcl_enc_t                enc_o
);
   initial begin
      sample_o = 1'b0;
      enc_o    = '0;
   end
   // both encoders latched in one cycle; idle data scrambled so it is never trusted
   // mark crossed in motion
   always @(posedge clk_i) begin
      if (run_i) begin
         sample_o <= 1'b1;
         enc_o    <= {mot_i, load_i, mark_i};
      end else begin
         sample_o <= 1'b0;
         enc_o    <= ~enc_o;
      end
   end
endmodule

// ---- fcl_top_test.sv ----
// fcl_top_test: directed scenarios for the closed loop feedback block
`timescale 1ns/1ps
module fcl_top_test;
   import fcl_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc, stb, we, run, mark, alarm, cmd, home, dog;
   logic [7:0]  adr;
   logic [31:0] wdat, q, fb;
   logic [15:0] mot, ld;
   logic        ack, smp, full, homed;
   logic [31:0] rdat;
   fcl_enc_t    enc;
   int          bad_count, total_checks, em, eg, el, gn, gd, hp;
   bit          pol;
   always #10 clk_i = ~clk_i;
   fcl_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .sample_i(smp), .enc_i(enc),
      .alarm_i(alarm), .loop_switch_cmd_i(cmd), .home_start_i(home), .dog_i(dog), .fb_pos_o(fb),
      .full_loop_o(full), .homed_o(homed));
   fcl_enc_model u_enc (.clk_i(clk_i), .run_i(run), .mot_i(mot), .load_i(ld), .mark_i(mark),
      .sample_o(smp), .enc_o(enc));
   // verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic cycle; waits for ack under a bound
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      // judge on ack itself, so an answer on the last try still counts
      if (ack !== 1'b1) begin
         bad_count++;
         close_out();
      end
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, q, exp);
   endtask
   // n control cycles of motion, expectations tracked alongside
   task automatic mv(input int n, input int m, input int l, input logic mk);
      run <= 1'b1; mot <= 16'(m); ld <= 16'(l); mark <= mk;
      repeat (n) @(posedge clk_i);
      run <= 1'b0; mark <= 1'b0;
      repeat (3) @(posedge clk_i);
      em += n * m;
      eg = em * gn / gd;
      if (!alarm) el += pol ? -n * l : n * l;
   endtask
   task automatic t_reset();
      rc(FCL_FILT, 32'h0A, "filt");
      rc(FCL_NUM_A, 32'h01, "num_a");
      wb(1'b1, FCL_MOT_CUM, 32'h05);
      rc(FCL_MOT_CUM, 32'h0, "ro_cum");
      rc(8'h40, 32'h0, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_gear();
      wb(1'b1, FCL_CTRL, 32'h01);
      wb(1'b1, FCL_NUM_A, 32'h03); gn = 3;
      wb(1'b1, FCL_DEN_A, 32'h02); gd = 2;
      mv(4, 2, 3, 0);
      rc(FCL_MOT_CUM, 32'(em), "mot_cum");
      rc(FCL_GEAR_CUM, 32'(eg), "gear_cum");
      rc(FCL_LOAD_CUM, 32'(el), "load_cum");
      wb(1'b0, FCL_STATUS, 32'h0);
      chk("match", 32'(q[FCL_ST_MATCH]), 32'h1);
      mv(3, 1, 0, 0);
      rc(FCL_GEAR_CUM, 32'(eg), "carry");
      $display("test gear done");
   endtask
   task automatic t_load();
      alarm <= 1'b1;
      mv(2, 2, 5, 0);
      alarm <= 1'b0;
      rc(FCL_LOAD_CUM, 32'(el), "alarm_hold");
      rc(FCL_MOT_CUM, 32'(em), "mot_same");
      wb(1'b1, FCL_CTRL, 32'h05); pol = 1;
      mv(2, 0, 3, 0);
      rc(FCL_LOAD_CUM, 32'(el), "polarity");
      wb(1'b1, FCL_CTRL, 32'h01); pol = 0;
      mv(1, 0, 2, 1);
      rc(FCL_LOAD_INFO, 32'h0, "info_clr");
      mv(2, 0, 1, 0);
      rc(FCL_LOAD_INFO, 32'h02, "info_cnt");
      $display("test load done");
   endtask
   task automatic t_mode();
      // back to the semi system for the mode zero checks
      wb(1'b1, FCL_CTRL, 32'h00);
      mv(1, 0, 0, 0);
      chk("fb_semi", fb, 32'(em));
      chk("full_m0", 32'(full), 32'h0);
      wb(1'b1, FCL_CTRL, 32'h01);
      mv(1, 0, 0, 0);
      chk("full_m1", 32'(full), 32'h1);
      wb(1'b1, FCL_CTRL, 32'h03);
      mv(1, 0, 0, 0);
      chk("fb_sw_off", fb, 32'(eg));
      chk("full_off", 32'(full), 32'h0);
      cmd <= 1'b1;
      wb(1'b1, FCL_FILT, 32'h1388);
      rc(FCL_FILT, 32'h1194, "clamp");
      // fb lags one sample behind the filter, so two samples each
      mv(2, 0, 0, 0);
      chk("full_on", 32'(full), 32'h1);
      chk("fb_full", fb, 32'(el));
      wb(1'b1, FCL_FILT, 32'h0);
      mv(2, 0, 0, 0);
      chk("fb_zero", fb, 32'(eg));
      wb(1'b1, FCL_FILT, 32'h08CA);
      mv(2, 0, 0, 0);
      chk("fb_blend", fb, 32'(eg + (el - eg) * 2250 / 4500));
      $display("test mode done");
   endtask
   task automatic dog_pass();
      dog <= 1'b1;
      @(posedge clk_i);
      dog <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic t_home();
      home <= 1'b1;
      @(posedge clk_i);
      home <= 1'b0;
      mv(2, 3, 0, 0);
      mv(1, 0, 4, 1); hp = el;
      dog_pass();
      chk("homed", 32'(homed), 32'h1);
      rc(FCL_HOME_POS, 32'(hp), "home_pos");
      home <= 1'b1;
      @(posedge clk_i);
      home <= 1'b0;
      mv(2, 3, 0, 0);
      dog_pass();
      chk("no_mark", 32'(homed), 32'h0);
      wb(1'b0, FCL_STATUS, 32'h0);
      chk("fail", 32'(q[FCL_ST_FAIL]), 32'h1);
      $display("test home done");
   endtask
   initial begin
      {cyc, stb, we, run, mark, alarm, cmd, home, dog, pol} = '0;
      {adr, wdat, mot, ld} = '0;
      {bad_count, total_checks, em, eg, el, hp} = '0;
      gn = 1;
      gd = 1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_gear();
      t_load();
      t_mode();
      t_home();
      close_out();
   end
endmodule
